//--- src/wpps_pkg.sv
// power packet sequencer constants: clock, coil timing, headers, windows
// assumes a single 50 MHz system clock and a same-clock demodulator
package wpps_pkg;

  // -----------------------------------------------------------------
  // clock and coil operating point
  // -----------------------------------------------------------------
  localparam int unsigned CLK_KHZ   = 50000;  // system clock rate
  localparam int unsigned PING_KHZ  = 175;    // ping frequency
  localparam int unsigned FMIN_KHZ  = 110;    // lowest drive frequency
  localparam int unsigned FMAX_KHZ  = 205;    // highest drive frequency
  localparam int unsigned PER_W     = 9;      // coil period width
  localparam logic [8:0]  PING_PER  = 9'(CLK_KHZ / PING_KHZ);
  localparam logic [8:0]  PER_MIN   = 9'(CLK_KHZ / FMAX_KHZ);
  localparam logic [8:0]  PER_MAX   = 9'(CLK_KHZ / FMIN_KHZ);

  // -----------------------------------------------------------------
  // packet header codes
  // -----------------------------------------------------------------
  localparam logic [7:0] HDR_SS    = 8'h01;  // signal strength
  localparam logic [7:0] HDR_EPT   = 8'h02;  // end power transfer
  localparam logic [7:0] HDR_CE    = 8'h03;  // control error
  localparam logic [7:0] HDR_RP    = 8'h04;  // rectified power
  localparam logic [7:0] HDR_CS    = 8'h05;  // charge status
  localparam logic [7:0] HDR_HOLD  = 8'h06;  // power control hold-off
  localparam logic [7:0] HDR_PROPA = 8'h18;  // proprietary, first code
  localparam logic [7:0] HDR_PROPB = 8'hF2;  // proprietary, second code
  localparam logic [7:0] HDR_CFG   = 8'h51;  // configuration
  localparam logic [7:0] HDR_ID    = 8'h71;  // identification
  localparam logic [7:0] HDR_XID   = 8'h81;  // extended identification
  localparam int unsigned EXT_BIT  = 7;      // ext flag in first msg byte
  localparam logic [2:0] OPT_MAX   = 3'h7;   // optional packets allowed

  // -----------------------------------------------------------------
  // protocol windows and delays, in microseconds
  // -----------------------------------------------------------------
  localparam int unsigned PING_WIN_US = 20000;  // ping to header start
  localparam int unsigned NEXT_WIN_US = 20000;  // stop bit to next header
  localparam int unsigned CE_WIN_US   = 20000;  // control error spacing
  localparam int unsigned RP_WIN_US   = 20000;  // config to rect. power
  localparam int unsigned RM_DLY_US   = 1000;   // removal delay
  localparam int unsigned SETTLE_US   = 5000;   // settling before apply
  localparam int unsigned CLK_MHZ     = CLK_KHZ / 1000;

  // -----------------------------------------------------------------
  // phases of the sequencer
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SELECT,
    ST_PING,
    ST_IDCFG,
    ST_XFER,
    ST_REMOVE
  } wpps_phase_e;

endpackage

//--- src/wpps_coil_pwm.sv
// coil drive generator: square wave at a programmable period, 50% duty
// assumes the period input is stable or changes only between cycles
`timescale 1ns/1ps
module wpps_coil_pwm #(
  parameter int unsigned PER_W = 9
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  input  wire logic             i_en,
  input  wire logic [PER_W-1:0] i_period,
  output logic                  o_drive
);

  // -----------------------------------------------------------------
  // parameter check
  // -----------------------------------------------------------------
  if (PER_W < 2) begin : g_chk
    $error("period width too small");
  end

  logic [PER_W-1:0] cnt_reg;   // position within the coil period
  logic [PER_W-1:0] per_reg;   // period in force for this cycle
  logic             drive_reg; // drive level
  wire  logic       wrap;      // last count of the period
  wire  logic [PER_W-1:0] half; // high half of the period

  assign wrap = (cnt_reg >= per_reg - 1'b1);
  assign half = per_reg >> 1;
  assign o_drive = drive_reg;

  // period taken only at a wrap, or while disabled, so each cycle is whole
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !i_en) begin
      cnt_reg   <= '0;
      per_reg   <= i_period;
      drive_reg <= 1'b0;
    end else begin
      cnt_reg   <= wrap ? '0 : cnt_reg + 1'b1;
      per_reg   <= wrap ? i_period : per_reg;
      drive_reg <= wrap ? 1'b1 : (cnt_reg + 1'b1 < half);
    end
  end

endmodule

//--- src/wpps_seq.sv
// transmitter phase and packet sequencer with control error settling
// assumes the demodulator runs on i_clk_sys and gives one-cycle pulses
// How it works
// - ping drives coil at fixed frequency, duty
// - phases: selection, ping, id/config, transfer
// - packets framed as header, message, checksum
// - no signal strength header: remove after delay
// - signal strength in ping enters id/config
// - other packet in ping terminates power
// - id, extended id if flagged, then config
// - up to seven optional packets before config
// - id/config keeps ping operating point
// - next header missing in window: remove power
// - late or out-of-order packet: remove after delay
// - first control error missing: remove power
// - control error timer restarts each control error packet
// - rectified power due after config window
// - transfer accepts listed packet kinds freely
// - control error applied after settling delay
// - sequence violation in transfer removes power
`timescale 1ns/1ps
module wpps_seq #(
  parameter int unsigned TW         = 24,
  parameter int unsigned P_PING_WIN = wpps_pkg::PING_WIN_US * 50,
  parameter int unsigned P_NEXT_WIN = wpps_pkg::NEXT_WIN_US * 50,
  parameter int unsigned P_CE_WIN   = wpps_pkg::CE_WIN_US * 50,
  parameter int unsigned P_RP_WIN   = wpps_pkg::RP_WIN_US * 50,
  parameter int unsigned P_RM_DLY   = wpps_pkg::RM_DLY_US * 50,
  parameter int unsigned P_SETTLE   = wpps_pkg::SETTLE_US * 50
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  input  wire logic       i_obj_detect,
  input  wire logic       i_hdr_start,
  input  wire logic       i_pkt_valid,
  input  wire logic       i_pkt_ok,
  input  wire logic [7:0] i_pkt_header,
  input  wire logic [7:0] i_pkt_msg0,
  output logic            o_power_en,
  output logic            o_coil_drive,
  output logic [2:0]      o_phase,
  output logic [8:0]      o_period,
  output logic            o_ce_apply,
  output logic [7:0]      o_ss_value,
  output logic            o_fault
);

  // -----------------------------------------------------------------
  // parameter check
  // -----------------------------------------------------------------
  if (TW > 31 || P_PING_WIN >= 2**TW || P_NEXT_WIN >= 2**TW ||
      P_CE_WIN >= 2**TW || P_RP_WIN >= 2**TW || P_RM_DLY >= 2**TW ||
      P_SETTLE >= 2**TW || P_SETTLE == 0) begin : g_chk
    $error("timer width cannot hold a window");
  end

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  wpps_pkg::wpps_phase_e st_reg, st_next;   // phase
  logic [TW-1:0] win_reg, win_next;         // window / removal countdown
  logic          wrun_reg, wrun_next;       // window running
  logic [1:0]    step_reg, step_next;       // 0 id, 1 ext id, 2 cfg
  logic [2:0]    opt_reg, opt_next;         // optional packets seen
  logic [TW-1:0] ce_reg, ce_next;           // control error countdown
  logic          ce1_reg, ce1_next;         // first control error awaited
  logic [TW-1:0] rp_reg, rp_next;           // rectified power countdown
  logic          rrun_reg, rrun_next;       // rectified power awaited
  logic [TW-1:0] stl_reg, stl_next;         // settle countdown
  logic          srun_reg, srun_next;       // settle running
  logic [7:0]    cev_reg, cev_next;         // pending control error
  logic [8:0]    per_reg, per_next;         // operating period
  logic          pwr_reg, pwr_next;         // power signal on
  logic          flt_reg, flt_next;         // removal was a fault
  logic          apl_reg, apl_next;         // control error applied
  logic [7:0]    ss_reg, ss_next;           // last signal strength
  logic          s1_reg, s2_reg, s3_reg;    // detect synchroniser
  logic          det_reg;                   // filtered detect level

  // -----------------------------------------------------------------
  // packet decode
  // -----------------------------------------------------------------
  wire logic good    = i_pkt_valid & i_pkt_ok;
  wire logic is_ss   = i_pkt_header == wpps_pkg::HDR_SS;
  wire logic is_ce   = i_pkt_header == wpps_pkg::HDR_CE;
  wire logic is_rp   = i_pkt_header == wpps_pkg::HDR_RP;
  wire logic is_ept  = i_pkt_header == wpps_pkg::HDR_EPT;
  wire logic is_id   = i_pkt_header == wpps_pkg::HDR_ID;
  wire logic is_xid  = i_pkt_header == wpps_pkg::HDR_XID;
  wire logic is_cfg  = i_pkt_header == wpps_pkg::HDR_CFG;
  wire logic is_prop = i_pkt_header == wpps_pkg::HDR_PROPA ||
                       i_pkt_header == wpps_pkg::HDR_PROPB;
  wire logic is_opt  = is_prop || i_pkt_header == wpps_pkg::HDR_HOLD;
  wire logic is_ok_x = is_ce || is_rp || is_prop ||
                       i_pkt_header == wpps_pkg::HDR_CS;
  wire logic ext_set = i_pkt_msg0[wpps_pkg::EXT_BIT];
  wire logic win_exp = wrun_reg && win_reg == '0;
  wire logic ce_exp  = ce_reg == '0;
  wire logic rp_exp  = rrun_reg && rp_reg == '0;
  wire logic stl_exp = srun_reg && stl_reg == '0;

  // settled operating point, clamped to the drive range
  wire logic signed [10:0] per_sum = $signed({2'b00, per_reg}) +
                                     $signed({{3{cev_reg[7]}}, cev_reg});
  wire logic [8:0] per_adj =
    (per_sum < $signed({2'b00, wpps_pkg::PER_MIN})) ? wpps_pkg::PER_MIN :
    (per_sum > $signed({2'b00, wpps_pkg::PER_MAX})) ? wpps_pkg::PER_MAX :
    per_sum[8:0];

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    logic kill_dly;  // remove power after the removal delay
    logic kill_now;  // remove power at once
    kill_dly  = 1'b0;
    kill_now  = 1'b0;
    st_next   = st_reg;
    win_next  = (wrun_reg && win_reg != '0) ? win_reg - 1'b1 : win_reg;
    wrun_next = wrun_reg;
    step_next = step_reg;
    opt_next  = opt_reg;
    ce_next   = ce_exp ? ce_reg : ce_reg - 1'b1;
    ce1_next  = ce1_reg;
    rp_next   = (rrun_reg && !rp_exp) ? rp_reg - 1'b1 : rp_reg;
    rrun_next = rrun_reg;
    stl_next  = (srun_reg && !stl_exp) ? stl_reg - 1'b1 : stl_reg;
    srun_next = srun_reg;
    cev_next  = cev_reg;
    per_next  = per_reg;
    pwr_next  = pwr_reg;
    flt_next  = flt_reg;
    apl_next  = 1'b0;
    ss_next   = ss_reg;
    unique case (st_reg)
      // idle until an object is reported
      wpps_pkg::ST_SELECT: begin
        pwr_next = 1'b0;
        if (det_reg) begin
          st_next   = wpps_pkg::ST_PING;
          pwr_next  = 1'b1;
          flt_next  = 1'b0;
          per_next  = wpps_pkg::PING_PER;
          win_next  = TW'(P_PING_WIN);
          wrun_next = 1'b1;
        end
      end
      // wait for signal strength
      wpps_pkg::ST_PING: begin
        if (i_hdr_start) wrun_next = 1'b0;
        if (good && is_ss) begin
          ss_next   = i_pkt_msg0;
          st_next   = wpps_pkg::ST_IDCFG;
          step_next = 2'h0;
          opt_next  = 3'h0;
          win_next  = TW'(P_NEXT_WIN);
          wrun_next = 1'b1;
        end else if (good) begin
          kill_dly = 1'b1;
        end else if (win_exp) begin
          kill_dly = 1'b1;
        end
      end
      // identification and configuration, operating point held
      wpps_pkg::ST_IDCFG: begin
        if (i_hdr_start) wrun_next = 1'b0;
        if (good) begin
          win_next  = TW'(P_NEXT_WIN);
          wrun_next = 1'b1;
          if (step_reg == 2'h0 && is_id) begin
            step_next = ext_set ? 2'h1 : 2'h2;
          end else if (step_reg == 2'h1 && is_xid) begin
            step_next = 2'h2;
          end else if (step_reg == 2'h2 && is_opt &&
                       opt_reg != wpps_pkg::OPT_MAX) begin
            opt_next = opt_reg + 1'b1;
          end else if (step_reg == 2'h2 && is_cfg) begin
            st_next   = wpps_pkg::ST_XFER;
            wrun_next = 1'b0;
            ce_next   = TW'(P_CE_WIN);
            ce1_next  = 1'b1;
            rp_next   = TW'(P_RP_WIN);
            rrun_next = 1'b1;
            srun_next = 1'b0;
          end else begin
            kill_dly = 1'b1;
          end
        end else if (win_exp) begin
          kill_dly = 1'b1;
        end
      end
      // power transfer
      wpps_pkg::ST_XFER: begin
        // settled change first, so a control error in the same cycle
        // restarts the settle count instead of being dropped
        if (stl_exp) begin
          srun_next = 1'b0;
          apl_next  = 1'b1;
          per_next  = per_adj;
        end
        if (good && is_ce) begin
          ce_next   = TW'(P_CE_WIN);
          ce1_next  = 1'b0;
          cev_next  = i_pkt_msg0;
          stl_next  = TW'(P_SETTLE - 1);
          srun_next = 1'b1;
        end
        if (good && is_rp) rrun_next = 1'b0;
        if (good && is_ept) begin
          kill_now = 1'b1;
        end else if (good && !is_ok_x) begin
          kill_now = 1'b1;
        end else if (ce_exp && ce1_reg) begin
          kill_dly = 1'b1;
        end else if (ce_exp || rp_exp) begin
          kill_now = 1'b1;
        end
      end
      // hold power for the removal delay, then drop it
      wpps_pkg::ST_REMOVE: begin
        if (win_reg == '0) begin
          st_next  = wpps_pkg::ST_SELECT;
          pwr_next = 1'b0;
        end
      end
      default: st_next = wpps_pkg::ST_SELECT;
    endcase
    if (kill_dly || kill_now) begin
      st_next   = wpps_pkg::ST_REMOVE;
      win_next  = kill_dly ? TW'(P_RM_DLY) : '0;
      wrun_next = 1'b1;
      rrun_next = 1'b0;
      srun_next = 1'b0;
      flt_next  = !(good && is_ept);
    end
  end

  // -----------------------------------------------------------------
  // detect synchroniser, agreement of second and third stage
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      det_reg <= 1'b0;
    end else begin
      s1_reg  <= i_obj_detect;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      det_reg <= (s2_reg == s3_reg) ? s3_reg : det_reg;
    end
  end

  // -----------------------------------------------------------------
  // state registers
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_reg <= wpps_pkg::ST_SELECT;
      win_reg <= '0;  wrun_reg <= 1'b0;
      step_reg <= 2'h0;  opt_reg <= 3'h0;
      ce_reg <= '0;  rp_reg <= '0;  rrun_reg <= 1'b0;
      ce1_reg <= 1'b0;
      stl_reg <= '0;  srun_reg <= 1'b0;  cev_reg <= 8'h00;
      per_reg <= wpps_pkg::PING_PER;
      pwr_reg <= 1'b0;  flt_reg <= 1'b0;  apl_reg <= 1'b0;
      ss_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      win_reg <= win_next;  wrun_reg <= wrun_next;
      step_reg <= step_next;  opt_reg <= opt_next;
      ce_reg <= ce_next;  rp_reg <= rp_next;  rrun_reg <= rrun_next;
      ce1_reg <= ce1_next;
      stl_reg <= stl_next;  srun_reg <= srun_next;  cev_reg <= cev_next;
      per_reg <= per_next;
      pwr_reg <= pwr_next;  flt_reg <= flt_next;  apl_reg <= apl_next;
      ss_reg <= ss_next;
    end
  end

  assign o_power_en = pwr_reg;
  assign o_phase    = st_reg;
  assign o_period   = per_reg;
  assign o_ce_apply = apl_reg;
  assign o_ss_value = ss_reg;
  assign o_fault    = flt_reg;

  // coil drive at the current operating point
  wpps_coil_pwm #(.PER_W(wpps_pkg::PER_W)) u_pwm (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_en      (pwr_reg),
    .i_period  (per_reg),
    .o_drive   (o_coil_drive)
  );

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_ce_rx;
    st_reg == wpps_pkg::ST_XFER && good && is_ce;
  endsequence

  AST_PING_POINT: assert property (
    st_reg == wpps_pkg::ST_PING |-> pwr_reg &&
      per_reg == wpps_pkg::PING_PER) else $error("ping point wrong");
  AST_IDCFG_POINT: assert property (
    st_reg == wpps_pkg::ST_IDCFG |-> $stable(per_reg) &&
      per_reg == wpps_pkg::PING_PER) else $error("id point moved");
  AST_PHASE_ORDER: assert property (
    st_reg == wpps_pkg::ST_PING ##1 st_reg != wpps_pkg::ST_PING |->
      st_reg inside {wpps_pkg::ST_IDCFG, wpps_pkg::ST_REMOVE})
    else $error("phase order broken");
  AST_SS_ADVANCE: assert property (
    st_reg == wpps_pkg::ST_PING && good && is_ss |=>
      st_reg == wpps_pkg::ST_IDCFG && ss_reg == $past(i_pkt_msg0))
    else $error("no id phase after strength");
  AST_PING_OTHER: assert property (
    st_reg == wpps_pkg::ST_PING && good && !is_ss |=>
      st_reg == wpps_pkg::ST_REMOVE && o_fault && o_power_en)
    else $error("bad ping packet kept");
  AST_PING_TIMEOUT: assert property (
    st_reg == wpps_pkg::ST_PING && !good && win_exp |=>
      st_reg == wpps_pkg::ST_REMOVE) else $error("ping timeout lost");
  AST_IDCFG_SEQ: assert property (
    st_reg == wpps_pkg::ST_IDCFG && good && step_reg == 2'h0 &&
      !is_id |=> st_reg == wpps_pkg::ST_REMOVE)
    else $error("order slip accepted");
  AST_OPT_LIMIT: assert property (
    st_reg == wpps_pkg::ST_IDCFG && good && step_reg == 2'h2 &&
      is_opt && opt_reg == wpps_pkg::OPT_MAX |=>
      st_reg == wpps_pkg::ST_REMOVE) else $error("eighth optional kept");
  AST_CE_SETTLE: assert property (
    s_ce_rx ##0 !stl_exp |=> !o_ce_apply ##0 per_reg == $past(per_reg))
    else $error("change applied without settling");
  AST_XFER_VIOL: assert property (
    st_reg == wpps_pkg::ST_XFER && good && !is_ok_x && !is_ept |=>
      st_reg == wpps_pkg::ST_REMOVE && win_reg == '0 && o_fault)
    else $error("violation not removed");
  AST_CE_TIMEOUT: assert property (
    st_reg == wpps_pkg::ST_XFER && ce_exp |=>
      st_reg == wpps_pkg::ST_REMOVE) else $error("ce timeout lost");
  AST_CE_FIRST: assert property (
    st_reg == wpps_pkg::ST_XFER && ce_exp && ce1_reg && !good |=>
      st_reg == wpps_pkg::ST_REMOVE && win_reg == TW'(P_RM_DLY))
    else $error("first ce timeout not delayed");

endmodule

//--- verification/wpps_rx_model.sv
// receiver model: frames packets toward the sequencer's demod inputs
// assumes i_clk_sys is the sequencer clock; drives on its falling edge
`timescale 1ns/1ps
module wpps_rx_model (
  input  wire logic       i_clk_sys,
  output logic            o_hdr_start,
  output logic            o_pkt_valid,
  output logic            o_pkt_ok,
  output logic [7:0]      o_pkt_header,
  output logic [7:0]      o_pkt_msg0
);
  // idle lines have no pull: they show the inverse of the last byte
  initial begin
    o_hdr_start  = 1'b0;
    o_pkt_valid  = 1'b0;
    o_pkt_ok     = 1'b0;
    o_pkt_header = 8'hFF;
    o_pkt_msg0   = 8'hFF;
  end
  // one packet: header start bit, bytes in flight, checksum stop bit
  task automatic send(input logic [7:0] hdr, input logic [7:0] msg,
                      input logic ok);
    @(negedge i_clk_sys);
    o_hdr_start  = 1'b1;
    @(negedge i_clk_sys);
    o_hdr_start  = 1'b0;
    repeat (4) @(negedge i_clk_sys);  // header, message, checksum
    o_pkt_header = hdr;
    o_pkt_msg0   = msg;
    o_pkt_ok     = ok;
    o_pkt_valid  = 1'b1;
    @(negedge i_clk_sys);
    o_pkt_valid  = 1'b0;
    o_pkt_ok     = ~ok;
    o_pkt_header = ~hdr;
    o_pkt_msg0   = ~msg;
  endtask
endmodule

//--- verification/test_wpps_seq.sv
// testbench: phase sequencing, windows, removal and settling checks
// assumes wpps_rx_model drives the demod side; no other partner
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  err_total++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module test_wpps_seq;
  // ---------------------------------------------------------------
  // short windows so the run stays brief
  // ---------------------------------------------------------------
  localparam int unsigned PW = 100;  // ping window
  localparam int unsigned NW = 100;  // id/config window
  localparam int unsigned CW = 150;  // control error spacing
  localparam int unsigned RW = 80;   // rectified power window
  localparam int unsigned RM = 50;   // removal delay
  localparam int unsigned ST = 20;   // settling delay
  localparam logic [2:0] PH_SEL = 3'(wpps_pkg::ST_SELECT);
  localparam logic [2:0] PH_PING = 3'(wpps_pkg::ST_PING);
  localparam logic [2:0] PH_ID = 3'(wpps_pkg::ST_IDCFG);
  localparam logic [2:0] PH_XF = 3'(wpps_pkg::ST_XFER);
  localparam logic [2:0] PH_RM = 3'(wpps_pkg::ST_REMOVE);
  logic       i_clk_sys;     // system clock
  logic       i_sys_rst;     // sync reset
  logic       i_obj_detect;  // object present
  logic       hdr_start, pkt_valid, pkt_ok;
  logic [7:0] pkt_header, pkt_msg0;
  logic       o_power_en, o_coil_drive, o_ce_apply, o_fault;
  logic [2:0] o_phase;
  logic [8:0] o_period;
  logic [7:0] o_ss_value;
  int         err_total   = 0;  // mismatches seen
  int         check_count = 0;  // comparisons made
  logic [7:0] opt [3] = '{wpps_pkg::HDR_HOLD, wpps_pkg::HDR_PROPA,
                          wpps_pkg::HDR_PROPB};
  // 50 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  wpps_seq #(.P_PING_WIN(PW), .P_NEXT_WIN(NW), .P_CE_WIN(CW),
    .P_RP_WIN(RW), .P_RM_DLY(RM), .P_SETTLE(ST)) i_wpps_seq (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_obj_detect(i_obj_detect), .i_hdr_start(hdr_start),
    .i_pkt_valid(pkt_valid), .i_pkt_ok(pkt_ok),
    .i_pkt_header(pkt_header), .i_pkt_msg0(pkt_msg0),
    .o_power_en(o_power_en), .o_coil_drive(o_coil_drive),
    .o_phase(o_phase), .o_period(o_period), .o_ce_apply(o_ce_apply),
    .o_ss_value(o_ss_value), .o_fault(o_fault));
  wpps_rx_model i_wpps_rx_model (
    .i_clk_sys(i_clk_sys), .o_hdr_start(hdr_start),
    .o_pkt_valid(pkt_valid), .o_pkt_ok(pkt_ok),
    .o_pkt_header(pkt_header), .o_pkt_msg0(pkt_msg0));
  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // poll at falling edges until the phase shows, bounded
  task automatic wait_phase(input logic [2:0] ph, input int n);
    int k;
    k = 0;
    while (o_phase !== ph && k < n) begin
      @(negedge i_clk_sys);
      k++;
    end
  endtask
  task automatic pkt(input logic [7:0] h, input logic [7:0] m);
    i_wpps_rx_model.send(h, m, 1'b1);
  endtask
  // reset for three cycles, then check idle outputs
  task automatic do_reset();
    i_sys_rst    = 1'b1;
    i_obj_detect = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    i_sys_rst    = 1'b0;
    `CHK("rst phase", PH_SEL, o_phase)
    `CHK("rst power", 1'b0, o_power_en)
    `CHK("rst period", wpps_pkg::PING_PER, o_period)
    `CHK("rst drive", 1'b0, o_coil_drive)
    `CHK("rst apply", 1'b0, o_ce_apply)
  endtask
  // object present, ping begins at the fixed operating point
  task automatic ping_on();
    i_obj_detect = 1'b1;
    wait_phase(PH_PING, 10);
    `CHK("ping phase", PH_PING, o_phase)
    `CHK("ping power", 1'b1, o_power_en)
    `CHK("ping period", wpps_pkg::PING_PER, o_period)
  endtask
  // walk into power transfer with a plain identification
  task automatic to_xfer();
    do_reset();
    ping_on();
    pkt(wpps_pkg::HDR_SS, 8'h40);
    pkt(wpps_pkg::HDR_ID, 8'h00);
    pkt(wpps_pkg::HDR_CFG, 8'h00);
    wait_phase(PH_XF, 4);
    `CHK("xfer phase", PH_XF, o_phase)
  endtask
  // removal: phase, fault, optional delay, then power off
  task automatic removal(input logic f, input int n, input logic dly);
    wait_phase(PH_RM, n);
    `CHK("rm phase", PH_RM, o_phase)
    `CHK("rm fault", f, o_fault)
    if (dly) begin
      repeat (RM - 3) @(negedge i_clk_sys);
      `CHK("rm delayed power", 1'b1, o_power_en)
    end
    i_obj_detect = 1'b0;
    wait_phase(PH_SEL, RM + 6);
    `CHK("rm power off", 1'b0, o_power_en)
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_full();
    do_reset();
    ping_on();
    pkt(wpps_pkg::HDR_SS, 8'hFF);
    wait_phase(PH_ID, 4);
    `CHK("id phase", PH_ID, o_phase)
    `CHK("strength", 8'hFF, o_ss_value)
    `CHK("coil on", 1'b1, o_coil_drive)
    pkt(wpps_pkg::HDR_ID, 8'h80);
    pkt(wpps_pkg::HDR_XID, 8'h00);
    for (int i = 0; i < 7; i++) pkt(opt[i % 3], 8'h00);
    `CHK("opt phase", PH_ID, o_phase)
    `CHK("id period", wpps_pkg::PING_PER, o_period)
    pkt(wpps_pkg::HDR_CFG, 8'h00);
    wait_phase(PH_XF, 4);
    `CHK("cfg phase", PH_XF, o_phase)
    pkt(wpps_pkg::HDR_CE, 8'h02);
    repeat (ST - 1) @(negedge i_clk_sys);
    `CHK("apply early", 1'b0, o_ce_apply)
    for (int k = 0; k < 4 && o_ce_apply !== 1'b1; k++)
      @(negedge i_clk_sys);
    `CHK("apply", 1'b1, o_ce_apply)
    @(negedge i_clk_sys);
    `CHK("period", wpps_pkg::PING_PER + 9'h002, o_period)
    pkt(wpps_pkg::HDR_RP, 8'h00);
    pkt(wpps_pkg::HDR_CS, 8'h00);
    pkt(wpps_pkg::HDR_PROPB, 8'h00);
    pkt(wpps_pkg::HDR_CE, 8'h00);
    `CHK("xfer stays", PH_XF, o_phase)
    pkt(wpps_pkg::HDR_EPT, 8'h00);
    removal(1'b0, 4, 1'b0);
    $display("test full sequence done");
  endtask
  task automatic t_ping();
    do_reset();
    ping_on();
    i_wpps_rx_model.send(wpps_pkg::HDR_RP, 8'h00, 1'b0);
    `CHK("bad sum ignored", PH_PING, o_phase)
    pkt(wpps_pkg::HDR_RP, 8'h00);
    removal(1'b1, 4, 1'b1);
    do_reset();
    ping_on();
    removal(1'b1, PW + 10, 1'b1);
    $display("test ping faults done");
  endtask
  task automatic t_idcfg();
    do_reset();
    ping_on();
    pkt(wpps_pkg::HDR_SS, 8'h10);
    pkt(wpps_pkg::HDR_CFG, 8'h00);
    removal(1'b1, 4, 1'b1);
    do_reset();
    ping_on();
    pkt(wpps_pkg::HDR_SS, 8'h10);
    removal(1'b1, NW + 10, 1'b1);
    do_reset();
    ping_on();
    pkt(wpps_pkg::HDR_SS, 8'h10);
    pkt(wpps_pkg::HDR_ID, 8'h00);
    for (int i = 0; i < 8; i++) pkt(opt[i % 3], 8'h00);
    removal(1'b1, 4, 1'b1);
    $display("test id/config faults done");
  endtask
  task automatic t_xfer();
    to_xfer();
    pkt(wpps_pkg::HDR_CE, 8'h00);
    removal(1'b1, RW + 4, 1'b0);
    to_xfer();
    pkt(wpps_pkg::HDR_RP, 8'h00);
    removal(1'b1, CW + 4, 1'b1);
    to_xfer();
    pkt(wpps_pkg::HDR_RP, 8'h00);
    pkt(wpps_pkg::HDR_CE, 8'h00);
    removal(1'b1, CW + 4, 1'b0);
    to_xfer();
    pkt(wpps_pkg::HDR_ID, 8'h00);
    removal(1'b1, 4, 1'b0);
    $display("test transfer faults done");
  endtask
  // main sequence
  initial begin
    t_full();
    t_ping();
    t_idcfg();
    t_xfer();
    summarize();
  end
  // watchdog well beyond the expected run of under two thousand cycles
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    err_total++;
    $display("watchdog expired");
    summarize();
  end
endmodule
